// ---- design/mdio_slave_regs.vh ----
// Purpose: constants for the clause 45 management slave
// Assumes: included by mdio_slave.v only
// Notes: frame field codes follow the clause 45 frame layout
`ifndef MDIO_SLAVE_REGS_VH
`define MDIO_SLAVE_REGS_VH
`define ST_C45 2'h0
`define OP_ADDR 2'h0
`define OP_WRITE 2'h1
`define OP_RDINC 2'h2
`define OP_READ 2'h3
`define TA_WR 2'h2
`define PRE_BITS 6'h20
`define DEV_PMA 5'h01
`define DEV_WIS 5'h02
`define DEV_PCS 5'h03
`define DEV_XGXS 5'h04
`define DEV_GLB 5'h1E
`define DEV_SEC 5'h1F
`define HDR_BITS 6'h0E
`define TA_BITS 6'h10
`define END_BITS 6'h20
`define CNT_ONE 6'h01
`define CNT_ZERO 6'h00
`define IDX_BITS 4
`define WIDE_BIT 15
`define ST_HI 13
`define ST_LO 12
`define OP_HI 11
`define OP_LO 10
`define PORT_HI 9
`define PORT_LO 6
`define CHAN_BIT 5
`define DEV_HI 4
`define DEV_LO 0
`endif

// ---- design/mdio_slave.v ----
// Purpose: clause 45 management slave, two channels, split 32-bit access
// Assumes: mdc and mdio_in are asynchronous pins; host keeps to link rate and ordering
// Notes: register space is a small array shared by both channels; address bit 15 marks 32-bit group
`timescale 1ns/100ps
`include "mdio_slave_regs.vh"

// Contract
// [RULE1] answer two port addresses: straps as upper four bits, channel as bit zero
// [RULE2] support address, write, read and read-increment clause 45 frames
// [RULE3] host keeps the management link at or below 2.5 Mbps
// [RULE4] host writes upper half first, then lower half, each after its address
// [RULE5] host never writes halves reversed nor only one half
// [RULE6] read-increment at lower-half address returns bits 15 to 0
// [RULE7] following plain read returns bits 31 to 16 at incremented address
// [RULE8] host repeats full three-step read for each 32-bit register
// [RULE9] each wide register reachable through an upper and a lower address
// [RULE10] only one register-access interface active; no arbitration here
// [RULE11] device field 1,2,3,4,1E,1F selects register groups; others ignored; here all six groups share one register array
// [RULE12] four strap bits allow sixteen devices on one host
// [RULE13] upper half staged; full word updates when lower half written
// [RULE14] read-increment captures upper half for the following read
module mdio_slave (
	// clock and control
	input wire clock,
	input wire rst,
	input wire clk_en,
	// strap pins
	input wire [3:0] port_strap,
	// management link
	input wire mdc,
	input wire mdio_in,
	output reg mdio_out_ff,
	output reg mdio_oe_n_ff
);

localparam S_IDLE = 2'h0;
localparam S_HDR = 2'h1;
localparam S_DATA = 2'h2;

reg [2:0] mdc_sync_ff;
reg [1:0] din_sync_ff;
reg [1:0] state_ff;
reg [5:0] cnt_ff;
reg [31:0] shift_ff;
reg [15:0] addr_ff [0:1];
reg [15:0] lo_mem [0:15];
reg [15:0] hi_mem [0:15];
reg [15:0] stage_ff [0:1];
reg [15:0] capt_ff [0:1];
reg [15:0] rd_ff;
reg [1:0] op_ff;
reg chan_ff;
reg hit_ff;
reg [3:0] strap_meta_ff;
reg [3:0] strap_ff;

wire mdc_rise = mdc_sync_ff[1] & ~mdc_sync_ff[2];
wire din = din_sync_ff[1];
wire [31:0] sh = {shift_ff[30:0], din};
// header fields, valid on the last header bit: current bit sits at sh[0]
wire [3:0] hdr_port = sh[`PORT_HI:`PORT_LO];
wire hdr_chan = sh[`CHAN_BIT];
wire [4:0] dev = sh[`DEV_HI:`DEV_LO];

// device field decode: unlisted groups are ignored
reg dev_ok;
always @* begin
	if (dev == `DEV_PMA) begin
		dev_ok = 1'h1; // [RULE11]
	end else if (dev == `DEV_WIS) begin
		dev_ok = 1'h1;
	end else if (dev == `DEV_PCS) begin
		dev_ok = 1'h1;
	end else if (dev == `DEV_XGXS) begin
		dev_ok = 1'h1;
	end else if (dev == `DEV_GLB) begin
		dev_ok = 1'h1;
	end else if (dev == `DEV_SEC) begin
		dev_ok = 1'h1;
	end else begin
		dev_ok = 1'h0;
	end
end

// port address: straps above, channel bit below
wire port_hit = (hdr_port == strap_ff); // [RULE1] [RULE12]
wire hdr_ok = (sh[`ST_HI:`ST_LO] == `ST_C45) && port_hit && dev_ok;
wire [15:0] cur = addr_ff[chan_ff];
wire [`IDX_BITS-1:0] idx = cur[`IDX_BITS:1];
wire wide = cur[`WIDE_BIT];
wire upper = cur[0];
// read side follows the channel of this header, chan_ff is still the old one
wire [15:0] rd_cur = addr_ff[hdr_chan];
wire [`IDX_BITS-1:0] rd_idx = rd_cur[`IDX_BITS:1];
wire rd_wide = rd_cur[`WIDE_BIT];
wire rd_upper = rd_cur[0];

// read data selection for the frame being started
reg [15:0] nxt_rd;
always @* begin
	nxt_rd = lo_mem[rd_idx];
	if (rd_wide && rd_upper) begin
		nxt_rd = capt_ff[hdr_chan]; // [RULE7] [RULE14]
	end else if (rd_wide) begin
		nxt_rd = lo_mem[rd_idx]; // [RULE6] [RULE9]
	end else begin
		nxt_rd = lo_mem[rd_idx];
	end
end

// pin synchronisers, frozen with the rest while clk_en is low
always @(posedge clock) begin
	if (rst) begin
		mdc_sync_ff <= 3'h0;
		din_sync_ff <= 2'h3;
		strap_meta_ff <= 4'h0;
		strap_ff <= 4'h0;
	end else if (clk_en) begin
		mdc_sync_ff <= {mdc_sync_ff[1:0], mdc};
		din_sync_ff <= {din_sync_ff[0], mdio_in};
		strap_meta_ff <= port_strap;
		strap_ff <= strap_meta_ff;
	end
end

integer i;
always @(posedge clock) begin
	if (rst) begin
		state_ff <= S_IDLE;
		cnt_ff <= `CNT_ZERO;
		shift_ff <= 32'h0;
		op_ff <= `OP_ADDR;
		chan_ff <= 1'h0;
		hit_ff <= 1'h0;
		rd_ff <= 16'h0;
		mdio_out_ff <= 1'h1;
		mdio_oe_n_ff <= 1'h1;
		addr_ff[0] <= 16'h0;
		addr_ff[1] <= 16'h0;
		stage_ff[0] <= 16'h0;
		stage_ff[1] <= 16'h0;
		capt_ff[0] <= 16'h0;
		capt_ff[1] <= 16'h0;
		for (i = 0; i < 16; i = i + 1) begin
			lo_mem[i] <= 16'h0;
			hi_mem[i] <= 16'h0;
		end
	end else if (clk_en) begin
		if (mdc_rise) begin
			shift_ff <= sh;
			case (state_ff)
			S_IDLE: begin
				// preamble of ones then start 00
				if (din) begin
					cnt_ff <= (cnt_ff == `PRE_BITS) ? cnt_ff : cnt_ff + `CNT_ONE;
				end else if (cnt_ff == `PRE_BITS) begin
					state_ff <= S_HDR;
					cnt_ff <= `CNT_ONE;
				end else begin
					cnt_ff <= `CNT_ZERO;
				end
			end
			S_HDR: begin
				cnt_ff <= cnt_ff + `CNT_ONE;
				if (cnt_ff == `HDR_BITS - `CNT_ONE) begin
					op_ff <= sh[`OP_HI:`OP_LO];
					chan_ff <= hdr_chan;
					hit_ff <= hdr_ok;
					// read frames: drive turnaround zero then data
					if (hdr_ok && sh[`OP_HI]) begin // [RULE2]
						rd_ff <= nxt_rd;
					end
				end else if (cnt_ff == `HDR_BITS) begin
					if (hit_ff && op_ff[1]) begin
						mdio_oe_n_ff <= 1'h0;
						mdio_out_ff <= 1'h0;
					end
				end else if (cnt_ff == `TA_BITS - `CNT_ONE) begin
					state_ff <= S_DATA;
					if (hit_ff && op_ff[1]) begin
						mdio_out_ff <= rd_ff[15];
						rd_ff <= {rd_ff[14:0], 1'h0};
					end
				end
			end
			default: begin
				cnt_ff <= cnt_ff + `CNT_ONE;
				if (hit_ff && op_ff[1]) begin
					mdio_out_ff <= rd_ff[15];
					rd_ff <= {rd_ff[14:0], 1'h0};
				end
				if (cnt_ff == `END_BITS - `CNT_ONE) begin
					state_ff <= S_IDLE;
					cnt_ff <= `CNT_ZERO;
					mdio_oe_n_ff <= 1'h1;
					mdio_out_ff <= 1'h1;
					if (hit_ff) begin
						case (op_ff)
						`OP_ADDR: addr_ff[chan_ff] <= sh[15:0];
						`OP_WRITE: begin
							if (wide && upper) begin
								stage_ff[chan_ff] <= sh[15:0]; // [RULE4] [RULE13]
							end else if (wide) begin
								lo_mem[idx] <= sh[15:0]; // [RULE13]
								hi_mem[idx] <= stage_ff[chan_ff];
							end else begin
								lo_mem[idx] <= sh[15:0];
							end
						end
						`OP_RDINC: begin
							addr_ff[chan_ff] <= cur + 16'h1; // [RULE7]
							capt_ff[chan_ff] <= hi_mem[idx]; // [RULE14]
						end
						default: begin
						end
						endcase
					end
				end
			end
			endcase
		end
	end
end

endmodule // mdio_slave

// ---- tb/mdio_slave_monitor.sv ----
// Purpose: pin checks of mdio_slave
// Assumes: mdc half period of 4 clocks
// Notes: bind at foot
`timescale 1ns/100ps
module mdio_slave_monitor (
	// control
	input wire clock,
	input wire rst,
	input wire clk_en,
	// link
	input wire mdc,
	input wire mdio_out_ff,
	input wire mdio_oe_n_ff
);
	wire d = mdio_out_ff;
	wire en_n = mdio_oe_n_ff;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	reset_idle_a: assert property (disable iff (1'b0) rst && clk_en |=> en_n && d) else $error("reset");
	state_freeze_a: assert property (!clk_en |=> $stable({d, en_n})) else $error("freeze");
	idle_high_a: assert property (en_n |-> d) else $error("idle");
	after_mdc_a: assert property (!$stable({d, en_n}) && !$past(rst) |-> $past(mdc, 3))
		else $error("mdc");
	ta_zero_a: assert property ($fell(en_n) |-> !d) else $error("ta");
	drive_len_a: assert property ($fell(en_n) |-> ##120 !en_n ##[8:24] en_n) else $error("len");
	bit_hold_a: assert property ($changed(d) && !en_n |=> $stable(d)[*4]) else $error("hold");
	quiet_start_a: assert property ($fell(rst) |-> en_n[*8]) else $error("start");
	cover property ($fell(en_n));
	cover property ($rose(en_n));
	cover property (!clk_en);
endmodule // mdio_slave_monitor
bind mdio_slave mdio_slave_monitor mon (.clock(clock), .rst(rst), .clk_en(clk_en), .mdc(mdc),
	.mdio_out_ff(mdio_out_ff), .mdio_oe_n_ff(mdio_oe_n_ff));

// ---- tb/mdio_host.sv ----
// Purpose: station host model
// Assumes: pull-up on the data line
// Notes: mdc idles low between frames
`timescale 1ns/100ps
module mdio_host (
	// link
	output reg mdc = 1'b0,
	output wire mdio_in,
	input wire mdio_out_ff,
	input wire mdio_oe_n_ff
);
	reg drv = 1'b1;
	assign mdio_in = mdio_oe_n_ff ? drv : mdio_out_ff;
	task frame(input [1:0] op, input [9:0] pd, input [15:0] d, output [15:0] q);
		reg [63:0] w;
		integer i;
		w = {32'hFFFFFFFF, 2'h0, op, pd, 2'h2, d};
		for (i = 63; i >= 0; i = i - 1) begin
			// released from turnaround on reads
			drv = (op[1] && i < 18) ? 1'b1 : w[i];
			#400 mdc = 1'b1;
			q = {q[14:0], mdio_in};
			#400 mdc = 1'b0;
		end
		drv = 1'b1;
	endtask
endmodule // mdio_host

// ---- tb/test_mdio_slave.sv ----
// Purpose: bench for mdio_slave
// Assumes: straps 4'h6, ports 0C and 0D
// Notes: frames come from mdio_host
`timescale 1ns/100ps
module test_mdio_slave;
	localparam [29:0] devs = {5'h01, 5'h02, 5'h03, 5'h04, 5'h1E, 5'h1F};
	reg clock = 1'b0;
	reg rst = 1'b1;
	reg clk_en = 1'b1;
	wire mdc, din, dout, oe_n;
	reg [15:0] q;
	integer n_fail = 0;
	integer n_tests = 0;
	integer i;
	always #50 clock = ~clock;
	mdio_slave dut (.clock(clock), .rst(rst), .clk_en(clk_en), .port_strap(4'h6), .mdc(mdc), .mdio_in(din),
		.mdio_out_ff(dout), .mdio_oe_n_ff(oe_n));
	mdio_host h (.mdc(mdc), .mdio_in(din), .mdio_out_ff(dout), .mdio_oe_n_ff(oe_n));
	task chk(input [15:0] seen, input [15:0] want);
		n_tests = n_tests + 1;
		if (seen !== want) begin
			n_fail = n_fail + 1;
			$display("BAD %0t got %h want %h", $time, seen, want);
		end
	endtask
	task f(input [1:0] op, input [9:0] pd, input [15:0] d);
		h.frame(op, pd, d, q);
	endtask
	task wide;
		f(2'h0, 10'h183, 16'h8003);
		f(2'h1, 10'h183, 16'hA5C3);
		f(2'h0, 10'h183, 16'h8002);
		f(2'h1, 10'h183, 16'h1E0F);
		for (i = 0; i < 2; i = i + 1) begin
			f(2'h0, {4'h6, i[0], 5'h03}, 16'h8002);
			f(2'h2, {4'h6, i[0], 5'h03}, 16'h0);
			chk(q, 16'h1E0F);
			f(2'h3, {4'h6, i[0], 5'h03}, 16'h0);
			chk(q, 16'hA5C3);
		end
		$display("wide done");
	endtask
	task decode;
		for (i = 0; i < 30; i = i + 5) begin
			f(2'h0, {5'h0D, devs[i +: 5]}, 16'h0004);
			f(2'h1, {5'h0D, devs[i +: 5]}, {11'h1E0, devs[i +: 5]});
			f(2'h3, {5'h0D, devs[i +: 5]}, 16'h0);
			chk(q, {11'h1E0, devs[i +: 5]});
		end
		f(2'h3, 10'h1C3, 16'h0);
		chk(q, 16'hFFFF);
		f(2'h3, 10'h1A5, 16'h0);
		chk(q, 16'hFFFF);
		$display("decode done");
	endtask
	task results;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#3000000 n_fail = n_fail + 1;
		results;
	end
	initial begin
		repeat (3) @(posedge clock);
		#10 rst = 1'b0;
		clk_en = 1'b0;
		chk({14'h0, dout, oe_n}, 16'h0003);
		repeat (3) @(posedge clock);
		#10 clk_en = 1'b1;
		wide;
		decode;
		results;
	end
endmodule // test_mdio_slave
